// >>> dv/lmt_link_asserts.sv
// checker for the training link: spacing, parking, feedback windows
// assumes link ck is mclk/4 and every link signal is seen on mclk
`timescale 1ns/1ps
module lmt_link_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs,
  input wire logic [2:0] cmd,
  input wire logic [7:0] ca,
  input wire logic dqs_t,
  input wire logic dqs_c,
  input wire logic [7:0] dq,
  input wire logic dq_d_oe,
  input wire logic odt_on,
  input wire logic boost_on
);
  import lmt_pkg::*;
  logic [7:0] gap_reg; // mclk cycles since cs last rose
  logic cs_prev_reg; // cs one cycle back
  logic [2:0] prev_reg; // command carried by the last cs
  logic [7:0] cap_reg; // payload at the last training cs
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // saturates so a long idle never wraps into a false short gap
  always_ff @(posedge mclk) begin
    if (sys_rst || (cs && !cs_prev_reg)) gap_reg <= 8'h01;
    else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
  end
  // a held training cs counts from its rising edge only
  always_ff @(posedge mclk) begin
    if (sys_rst) cs_prev_reg <= 1'b0;
    else cs_prev_reg <= cs;
  end
  // remembers what the next spacing depends on
  always_ff @(posedge mclk) begin
    if (sys_rst) prev_reg <= LMT_NOP;
    else if (cs) prev_reg <= cmd;
  end
  // training pattern the device must echo
  always_ff @(posedge mclk) begin
    if (!cke && cs) cap_reg <= ca;
  end
  a_odt_from_cke: assert property (odt_on == !cke)
    else $error("termination not tracking cke");
  a_mrw_gap_kept: assert property (
    cs && prev_reg == LMT_MRW |-> gap_reg >= 8'h28)
    else $error("command too soon after mode write");
  a_mrr_gap_kept: assert property (
    cs && prev_reg == LMT_MRR |-> gap_reg >= 8'h20)
    else $error("command too soon after mode read");
  a_wake_to_read: assert property (
    cs && cmd == LMT_MRR && prev_reg == LMT_WAKE |-> gap_reg >= 8'h40)
    else $error("mode read too soon after wake");
  a_strobe_parked: assert property (
    $fell(cke) |-> !$past(dqs_t) && $past(dqs_c))
    else $error("strobe not parked before cke fall");
  a_cs_to_strobe: assert property (
    !cke && $rose(dqs_t) |-> gap_reg >= 8'h08)
    else $error("strobe toggled too soon after cs");
  a_cbt_readback: assert property (
    !cke && cs |-> ##[1:2] (dq_d_oe && dq == cap_reg))
    else $error("training pattern late or wrong");
  a_level_feedback: assert property (
    $rose(dqs_t) && prev_reg == LMT_LVL |->
      ##[1:2] (dq_d_oe && (dq == 8'h00 || dq == 8'hFF)))
    else $error("leveling feedback late");
  a_level_wait: assert property (
    $rose(dqs_t) && prev_reg == LMT_LVL |-> gap_reg >= 8'hA0)
    else $error("leveling strobe too early");
  a_boost_drop: assert property (
    cs && cmd == LMT_BOOST_OFF |-> ##[1:4] !boost_on)
    else $error("vref boost not dropped in time");
  a_ck_divided: assert property (
    $rose(ck) |-> ck ##1 ck ##1 !ck ##1 !ck ##1 ck)
    else $error("link clock not steady");
endmodule // lmt_link_asserts

// >>> dv/tb_top.sv
// bench: host and device joined by the link, checked against a model
// assumes 40 MHz mclk; inputs change on the falling edge
`timescale 1ns/1ps
module tb_top;
  import lmt_pkg::*;
  logic mclk = 1'b0; // system clock
  logic sys_rst = 1'b1; // sync reset
  logic req_valid = 1'b0; // request present
  lmt_cmd_t req_cmd = LMT_NOP; // request code
  logic [7:0] req_ca = 8'h00; // request payload
  logic req_ready, rsp_valid, boost_state; // design outputs
  logic [7:0] rsp_data, last_ca; // design data outputs
  integer miscompares = 0; // mismatches seen
  integer samples_checked = 0; // comparisons made
  integer seed = 11419; // random seed
  integer cyc = 0; // mclk count
  integer last_take = 0; // cycle of last taken request
  integer exp_rsp; // popped readback, -1 means either clock level (00 or FF)
  lmt_cmd_t last_cmd = LMT_NOP; // code of last taken request
  logic [10:0] cs_q[$]; // expected link commands
  integer rsp_q[$]; // expected training responses
  lmt_cmd_t seq[12] = '{LMT_MRW, LMT_MRW, LMT_MRR, LMT_MRW, LMT_WAKE,
    LMT_MRR, LMT_CBT, LMT_CBT, LMT_VREF, LMT_LVL, LMT_BOOST_OFF, LMT_MRR};
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  lmt_link_if u_lmt_link_if ();
  lmt_host u_lmt_host (.mclk(mclk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_ca(req_ca),
    .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .link(u_lmt_link_if));
  lmt_dev u_lmt_dev (.mclk(mclk), .sys_rst(sys_rst), .last_ca(last_ca),
    .boost_state(boost_state), .link(u_lmt_link_if));
  lmt_link_asserts u_lmt_link_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .ck(u_lmt_link_if.ck), .cke(u_lmt_link_if.cke),
    .cs(u_lmt_link_if.cs), .cmd(u_lmt_link_if.cmd),
    .ca(u_lmt_link_if.ca), .dqs_t(u_lmt_link_if.dqs_t),
    .dqs_c(u_lmt_link_if.dqs_c), .dq(u_lmt_link_if.dq),
    .dq_d_oe(u_lmt_link_if.dq_d_oe), .odt_on(u_lmt_link_if.odt_on),
    .boost_on(u_lmt_link_if.boost_on));
  // one comparison, reported at once
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // spacing in mclk cycles: one link clock is four mclk
  function automatic integer min_gap(input lmt_cmd_t c);
    case (c)
      LMT_MRW: min_gap = 40; // 10 nCK beats 14 ns
      LMT_MRR: min_gap = 32; // 8 nCK
      LMT_WAKE: min_gap = 64; // wake 5 + row 8 + 3 nCK
      LMT_CBT, LMT_VREF: min_gap = 4; // 20 ns, 80 ns rounded up
      default: min_gap = 1;
    endcase
  endfunction
  // holds the request until ready is seen at a rising edge
  // ready is read before the edge's updates land, as the design sees it
  task automatic do_req(input lmt_cmd_t c, input logic [7:0] d);
    integer n;
    n = 0;
    @(negedge mclk);
    req_cmd = c;
    req_ca = d;
    req_valid = 1'b1;
    @(posedge mclk);
    while (req_ready !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    check(n < 3000, "request never taken");
    check(cyc - last_take >= min_gap(last_cmd), "spacing short");
    if (!(c inside {LMT_CBT, LMT_VREF, LMT_LVL})) cs_q.push_back({c, d});
    if (c == LMT_CBT) rsp_q.push_back(int'(d));
    if (c == LMT_LVL) rsp_q.push_back(-1);
    last_take = cyc;
    last_cmd = c;
    @(negedge mclk);
    req_valid = 1'b0;
  endtask
  // link command monitor, sampled mid-cycle where cs stands
  always @(negedge mclk) begin
    if (!sys_rst && u_lmt_link_if.cs === 1'b1 && u_lmt_link_if.cke === 1'b1
        && !(u_lmt_link_if.cmd inside {LMT_CBT, LMT_VREF, LMT_LVL})) begin
      check(cs_q.size() > 0 && cs_q[0] === {u_lmt_link_if.cmd,
        u_lmt_link_if.ca}, "wrong command on link");
      if (cs_q.size() > 0) void'(cs_q.pop_front());
    end
  end
  // training response monitor
  always @(negedge mclk) begin
    if (!sys_rst && rsp_valid === 1'b1) begin
      check(rsp_q.size() > 0, "response without request");
      if (rsp_q.size() > 0) begin
        exp_rsp = rsp_q.pop_front();
        if (exp_rsp >= 0) begin
          check(rsp_data === exp_rsp[7:0], "readback data");
          check(last_ca === exp_rsp[7:0], "device capture");
        end else begin
          check(rsp_data === 8'h00 || rsp_data === 8'hFF, "level");
        end
      end
    end
  end
  task automatic complete_run;
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, far beyond the thousand or so cycles expected
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    complete_run;
  end
  // main sequence
  initial begin
    integer n;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    check(boost_state === 1'b1, "boost not set after reset");
    foreach (seq[i]) do_req(seq[i], 8'($random(seed)));
    n = 0;
    while (rsp_q.size() > 0 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    check(n < 3000, "training response missing");
    check(boost_state === 1'b0, "boost still on");
    check(u_lmt_link_if.boost_on === 1'b0, "link boost on");
    do_req(LMT_MRW, 8'($random(seed)));
    @(negedge mclk); // let the monitor see the last command first
    sys_rst = 1'b1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    cs_q.delete();
    last_cmd = LMT_NOP;
    check(boost_state === 1'b1, "boost after second reset");
    do_req(LMT_CBT, 8'($random(seed)));
    do_req(LMT_MRW, 8'($random(seed)));
    do_req(LMT_MRR, 8'($random(seed)));
    repeat (200) @(negedge mclk);
    check(rsp_q.size() == 0 && cs_q.size() == 0, "work left over");
    complete_run;
  end
endmodule // tb_top

// >>> logic/lmt_dev.sv
// device end: training readback, leveling feedback, boost, odt
// assumes host keeps its spacing; link clock sampled on mclk
`timescale 1ns/1ps
`include "lmt_params.svh"
module lmt_dev (
  input wire logic mclk,
  input wire logic sys_rst,
  output logic [7:0] last_ca,
  output logic boost_state,
  lmt_link_if.dev link
);
  import lmt_pkg::*;

  logic [2:0] ck_sync; // three-stage sampler of link clock
  logic dqs_prev_reg; // strobe one cycle back
  logic ck_lvl_reg; // agreed clock level
  logic lvl_mode_reg; // leveling armed, else training
  logic dqs_rise; // strobe rising
  logic [7:0] cap_reg; // captured training pattern
  logic [`LMT_CW-1:0] off_reg; // boost-off timer

  // level changes when stages 2 and 3 agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ck_sync <= 3'h0;
      dqs_prev_reg <= 1'b0;
      ck_lvl_reg <= 1'b0;
    end else begin
      ck_sync <= {ck_sync[1:0], link.ck};
      dqs_prev_reg <= link.dqs_t;
      if (ck_sync[1] == ck_sync[2]) begin
        ck_lvl_reg <= ck_sync[2];
      end
    end
  end
  // strobe is mclk logic: no sampler, so a one-cycle pulse is still seen
  assign dqs_rise = link.dqs_t && !dqs_prev_reg;

  // mode follows the last leveling or training command
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lvl_mode_reg <= 1'b0;
    end else if (link.cs && link.cmd == LMT_LVL) begin
      lvl_mode_reg <= 1'b1;
    end else if (link.cs && link.cmd == LMT_CBT) begin
      lvl_mode_reg <= 1'b0;
    end
  end

  // last training sample wins when spacing is short
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cap_reg <= 8'h00;
    end else if (link.cs && link.cmd == LMT_CBT) begin
      cap_reg <= link.ca;
    end
  end
  assign last_ca = cap_reg;

  // drive pattern during training, clock level on leveling edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link.dq_d <= 8'h00;
      link.dq_d_oe <= 1'b0;
    end else begin
      link.dq_d_oe <= !link.cke;
      // training strobe only latches vref; it must not spoil the pattern
      if (dqs_rise && lvl_mode_reg) begin
        link.dq_d <= {8{ck_lvl_reg}};
      end else if (!link.cke && !lvl_mode_reg) begin
        link.dq_d <= cap_reg;
      end
    end
  end

  // termination on at once when cke drops
  assign link.odt_on = !link.cke;

  // boost drops within 100 ns of disable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      off_reg <= '0;
      link.boost_on <= 1'b1;
    end else if (link.cs && link.cmd == LMT_BOOST_OFF) begin
      off_reg <= `LMT_CW'(`LMT_CDIV(`LMT_BOOST_OFF_PS) - 1);
    end else if (off_reg != '0) begin
      off_reg <= off_reg - 1'b1;
      if (off_reg == `LMT_CW'(1)) begin
        link.boost_on <= 1'b0;
      end
    end
  end
  assign boost_state = link.boost_on;
endmodule // lmt_dev

// >>> logic/lmt_gap_cnt.sv
// minimum-delay down counter; busy while counting
// assumes load is a single-cycle strobe
`timescale 1ns/1ps
`include "lmt_params.svh"
module lmt_gap_cnt (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [`LMT_CW-1:0] count,
  output logic busy
);
  logic [`LMT_CW-1:0] cnt_reg; // cycles left
  // load wins, then count down to zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  assign busy = (cnt_reg != '0);
endmodule // lmt_gap_cnt

// >>> logic/lmt_host.sv
// host sequencer end: command spacing, training entry and exit
// assumes the user presents one request and holds it until taken
//
// Operation
// - MR writes apart by max(10ns,10 clocks)
// - MR read then next command: 8 clocks
// - MR write to dependent command: max(14ns,10)
// - read after wake: row delay plus 3
// - boot clock period at least 18 ns
// - device drops vref boost within 100 ns
// - clock valid max(7.5ns,5) after cke low
// - strobe parked 10 ns before cke falls
// - device shows training pattern within 20 ns
// - training commands spaced by readback time
// - allow 80 ns after single vref step
// - two clocks from cs to strobe toggle
// - clock valid 2 clocks plus wake delay
// - clock valid max(7.5ns,5) after cs high
// - termination active immediately on cke low
// - 20 clocks after leveling before strobe
// - leveling preamble of 20 clocks
// - device returns clock level within 20 ns; the device model drives it one mclk (25 ns) after the strobe rise
// - clock valid max(7.5ns,4) after last strobe
// - time and count must both elapse
`timescale 1ns/1ps
`include "lmt_params.svh"
module lmt_host (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire lmt_pkg::lmt_cmd_t req_cmd,
  input wire logic [7:0] req_ca,
  output logic req_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  lmt_link_if.host link
);
  import lmt_pkg::*;

  // counter loads, cycles derived from time and nCK
  localparam logic [`LMT_CW-1:0] MRW_CY = `LMT_CW'(`LMT_MAX(
    `LMT_CDIV(`LMT_MRW_GAP_PS), `LMT_MRW_GAP_NCK) * `LMT_LINK_DIV);
  localparam logic [`LMT_CW-1:0] MRD_CY = `LMT_CW'(`LMT_MAX(
    `LMT_CDIV(`LMT_MRD_PS), `LMT_MRD_NCK) * `LMT_LINK_DIV);
  localparam logic [`LMT_CW-1:0] MRR_CY =
    `LMT_CW'(`LMT_MRR_GAP_NCK * `LMT_LINK_DIV);
  localparam logic [`LMT_CW-1:0] WAKE_CY = `LMT_CW'((`LMT_XP_NCK +
    `LMT_RCD_NCK + `LMT_WAKE_EXTRA_NCK) * `LMT_LINK_DIV);
  localparam logic [`LMT_CW-1:0] CBT_CY = `LMT_CW'(`LMT_MAX(
    `LMT_CDIV(`LMT_ADR_PS), 1) * `LMT_LINK_DIV);
  localparam logic [`LMT_CW-1:0] VREF_CY =
    `LMT_CW'(`LMT_CDIV(`LMT_VREF_STEP_PS));
  localparam logic [`LMT_CW-1:0] PRE_CY = `LMT_CW'(`LMT_MAX(
    `LMT_CDIV(`LMT_STROBE_PRE_PS), 1));
  localparam logic [`LMT_CW-1:0] HOLD_CY = `LMT_CW'(`LMT_MAX(
    `LMT_CDIV(`LMT_CKE_HOLD_PS), `LMT_CKE_HOLD_NCK) * `LMT_LINK_DIV);
  localparam logic [`LMT_CW-1:0] LVL_CY = `LMT_CW'((`LMT_LVL_EN_NCK +
    `LMT_LVL_PRE_NCK) * `LMT_LINK_DIV);
  localparam logic [`LMT_CW-1:0] CS_CY = `LMT_CW'((`LMT_PRE_CS_NCK +
    `LMT_XP_NCK + `LMT_CS_STROBE_NCK) * `LMT_LINK_DIV);
  localparam logic [`LMT_CW-1:0] FB_CY =
    `LMT_CW'(`LMT_CDIV(`LMT_LVL_FB_PS) + 4);

  // sequencer phases
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_PARK = 3'b001,
    HS_CKELO = 3'b010,
    HS_CSUP = 3'b011,
    HS_STRB = 3'b100,
    HS_WAIT = 3'b101
  } hs_state_t;

  hs_state_t st_reg; // current phase
  lmt_cmd_t cur_reg; // command in flight
  logic [1:0] div_reg; // link clock divider
  logic ck_reg; // link clock level
  logic [`LMT_CW-1:0] tmr_reg; // phase timer
  logic mrw_busy; // mode write gap running
  logic mrd_busy; // dependent-command gap running
  logic gen_busy; // generic gap running
  logic mrw_load; // start write gap
  logic mrd_load; // start set delay
  logic gen_load; // start generic gap
  logic [`LMT_CW-1:0] gen_cnt; // generic gap length
  logic take; // request accepted

  // divider makes a 4x slower link clock, 100 ns period > 18 ns
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_reg <= 2'h0;
      ck_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      // toggle every second mclk: 50 ns half period, nCK = 4 mclk
      if (div_reg == 2'h1 || div_reg == 2'h3) begin
        ck_reg <= ~ck_reg;
      end
    end
  end
  // clock never stops, so every hold window is met
  assign link.ck = ck_reg;

  // refuse while any applicable counter runs
  assign req_ready = (st_reg == HS_IDLE) && !gen_busy && !mrd_busy &&
    !(mrw_busy && req_cmd == LMT_MRW);
  assign take = req_valid && req_ready;

  assign mrw_load = take && req_cmd == LMT_MRW;
  assign mrd_load = mrw_load;

  // one generic counter, its load chosen per command class
  always_comb begin
    gen_load = take;
    unique case (req_cmd)
      LMT_MRR: gen_cnt = MRR_CY;
      LMT_WAKE: gen_cnt = WAKE_CY;
      LMT_CBT: gen_cnt = CBT_CY;
      LMT_VREF: gen_cnt = VREF_CY;
      LMT_BOOST_OFF: gen_cnt = `LMT_CW'(`LMT_CDIV(`LMT_BOOST_OFF_PS));
      default: gen_cnt = `LMT_CW'(`LMT_LINK_DIV);
    endcase
  end

  lmt_gap_cnt u_mrw (.mclk(mclk), .sys_rst(sys_rst), .load(mrw_load),
    .count(MRW_CY), .busy(mrw_busy));
  lmt_gap_cnt u_mrd (.mclk(mclk), .sys_rst(sys_rst), .load(mrd_load),
    .count(MRD_CY), .busy(mrd_busy));
  lmt_gap_cnt u_gen (.mclk(mclk), .sys_rst(sys_rst), .load(gen_load),
    .count(gen_cnt), .busy(gen_busy));

  // training and leveling sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= HS_IDLE;
      cur_reg <= LMT_NOP;
      tmr_reg <= '0;
    end else begin
      if (tmr_reg != '0) begin
        tmr_reg <= tmr_reg - 1'b1;
      end
      unique case (st_reg)
        HS_IDLE: begin
          if (take && (req_cmd == LMT_CBT || req_cmd == LMT_LVL)) begin
            cur_reg <= req_cmd;
            st_reg <= HS_PARK;
            tmr_reg <= PRE_CY;
          end
        end
        HS_PARK: begin
          if (tmr_reg == '0) begin
            st_reg <= HS_CKELO;
            tmr_reg <= (cur_reg == LMT_LVL) ? LVL_CY : HOLD_CY;
          end
        end
        HS_CKELO: begin
          // leveling waits enable time and preamble
          if (tmr_reg == '0) begin
            st_reg <= (cur_reg == LMT_LVL) ? HS_STRB : HS_CSUP;
            tmr_reg <= (cur_reg == LMT_LVL) ? `LMT_CW'(4) : CS_CY;
          end
        end
        HS_CSUP: begin
          // cs high, strobe latch after cs gap
          if (tmr_reg == '0) begin
            st_reg <= HS_STRB;
            tmr_reg <= FB_CY;
          end
        end
        HS_STRB: begin
          if (tmr_reg == '0) begin
            st_reg <= HS_WAIT;
            tmr_reg <= `LMT_CW'(`LMT_MAX(`LMT_CDIV(`LMT_POST_DQS_PS),
              `LMT_POST_DQS_NCK) * `LMT_LINK_DIV);
          end
        end
        HS_WAIT: begin
          if (tmr_reg == '0) begin
            st_reg <= HS_IDLE;
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end

  // pins follow the phase; strobe parked low/high before cke falls
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link.cke <= 1'b1;
      link.cs <= 1'b0;
      link.cmd <= LMT_NOP;
      link.ca <= 8'h00;
      link.dqs_t <= 1'b0;
      link.dqs_c <= 1'b1;
      link.dq_h <= 8'h00;
      link.dq_h_oe <= 1'b0;
    end else begin
      link.cke <= !(st_reg == HS_CKELO || st_reg == HS_CSUP ||
        st_reg == HS_STRB);
      link.cs <= take || st_reg == HS_CSUP;
      link.cmd <= take ? req_cmd : LMT_NOP;
      link.ca <= take ? req_ca : link.ca;
      link.dq_h <= req_ca;
      link.dq_h_oe <= 1'b0;
      link.dqs_t <= (st_reg == HS_STRB) && (tmr_reg == `LMT_CW'(2));
      link.dqs_c <= !((st_reg == HS_STRB) && (tmr_reg == `LMT_CW'(2)));
    end
  end

  // capture device feedback at strobe phase end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (st_reg == HS_STRB) && (tmr_reg == '0);
      if ((st_reg == HS_STRB) && (tmr_reg == '0)) begin
        rsp_data <= link.dq;
      end
    end
  end
endmodule // lmt_host

// >>> logic/lmt_link_if.sv
// link between host sequencer and memory device model
// dq is two-way: wire level resolved from the enables here
`timescale 1ns/1ps
interface lmt_link_if;
  logic ck; // command clock made by host divider
  logic cke; // clock enable
  logic cs; // chip select
  logic [2:0] cmd; // command code
  logic [7:0] ca; // command address payload
  logic dqs_t; // true strobe
  logic dqs_c; // complement strobe
  logic [7:0] dq_h; // host drive value
  logic dq_h_oe; // host drives dq
  logic [7:0] dq_d; // device drive value
  logic dq_d_oe; // device drives dq
  logic odt_on; // device termination active
  logic boost_on; // device vref boost active
  wire [7:0] dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'h00);
  modport host (output ck, cke, cs, cmd, ca, dqs_t, dqs_c, dq_h,
    dq_h_oe, input dq, odt_on, boost_on);
  modport dev (input ck, cke, cs, cmd, ca, dqs_t, dqs_c, dq,
    output dq_d, dq_d_oe, odt_on, boost_on);
endinterface

// >>> logic/lmt_params.svh
// timing constants for the training and mode register link
// assumes a 40 MHz mclk (25 ns period)
`ifndef LMT_PARAMS_SVH
`define LMT_PARAMS_SVH
`define LMT_CLK_PS 25000
`define LMT_MRW_GAP_PS 10000
`define LMT_MRW_GAP_NCK 10
`define LMT_MRR_GAP_NCK 8
`define LMT_MRD_PS 14000
`define LMT_MRD_NCK 10
`define LMT_WAKE_EXTRA_NCK 3
`define LMT_RCD_NCK 8
`define LMT_XP_NCK 5
`define LMT_BOOT_PERIOD_PS 18000
`define LMT_BOOST_OFF_PS 100000
`define LMT_CKE_HOLD_PS 7500
`define LMT_CKE_HOLD_NCK 5
`define LMT_STROBE_PRE_PS 10000
`define LMT_ADR_PS 20000
`define LMT_VREF_STEP_PS 80000
`define LMT_CS_STROBE_NCK 2
`define LMT_PRE_CS_NCK 2
`define LMT_POST_CS_PS 7500
`define LMT_POST_CS_NCK 5
`define LMT_LVL_EN_NCK 20
`define LMT_LVL_PRE_NCK 20
`define LMT_LVL_FB_PS 20000
`define LMT_POST_DQS_PS 7500
`define LMT_POST_DQS_NCK 4
`define LMT_LINK_DIV 4
`define LMT_CW 8
`define LMT_CDIV(ps) (((ps) + `LMT_CLK_PS - 1) / `LMT_CLK_PS)
`define LMT_MAX(a, b) (((a) > (b)) ? (a) : (b))
`endif

// >>> logic/lmt_pkg.sv
// shared types for the training link ends
// constants live in lmt_params.svh
package lmt_pkg;
  // host commands on the command bus
  typedef enum logic [2:0] {
    LMT_NOP = 3'h0,
    LMT_MRW = 3'h1,
    LMT_MRR = 3'h2,
    LMT_CBT = 3'h3,
    LMT_LVL = 3'h4,
    LMT_BOOST_OFF = 3'h5,
    LMT_WAKE = 3'h6,
    LMT_VREF = 3'h7
  } lmt_cmd_t;
endpackage
